// File: src/cap_sense_regs.vh
`ifndef CAP_SENSE_REGS_VH
`define CAP_SENSE_REGS_VH

// ************************************************
// Register addresses and reset values
// ************************************************
`define CHAN_SEL_ADDR      8'h9C
`define TIMING_CFG_ADDR    8'hBE
`define CHAN_SEL_RESET     8'h00
`define TIMING_CFG_RESET   8'h40

// ************************************************
// Field positions
// ************************************************
`define RATE_MSB           7
`define RATE_LSB           6
`define DISCH_MSB          5
`define DISCH_LSB          3
`define CURR_MSB           2
`define CURR_LSB           0
`define DISC_BIT           7
`define RSVD_BIT           6
`define CHAN_MSB           5
`define CHAN_LSB           0

// ************************************************
// Timing: discharge lengths in 50 ns core clocks
// ************************************************
`define CLK_PERIOD_NS      50
`define DISCH_CYC_0        8'h0F
`define DISCH_CYC_1        8'h14
`define DISCH_CYC_2        8'h18
`define DISCH_CYC_3        8'h1E
`define DISCH_CYC_4        8'h28
`define DISCH_CYC_5        8'h3C
`define DISCH_CYC_6        8'h78
`define DISCH_CYC_7        8'hF0

// Conversion lengths in converter clocks
`define CONV_LEN_0         5'h0C
`define CONV_LEN_1         5'h0D
`define CONV_LEN_2         5'h0E
`define CONV_LEN_3         5'h10

// Full charge current in eighths
`define CURR_FULL_EIGHTHS  4'h8

`endif

// File: src/discharge_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_regs.vh"

// ************************************************
// Discharge pulse generator
// ************************************************
module discharge_timer (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       start,
	input  wire [2:0] sel,
	output reg        active_q
);

	reg [7:0] cnt_q;

	// Discharge length in whole core clocks
	function [7:0] cycles;
		input [2:0] s;
		begin
			case (s)
				3'h0:    cycles = `DISCH_CYC_0;
				3'h1:    cycles = `DISCH_CYC_1;
				3'h2:    cycles = `DISCH_CYC_2;
				3'h3:    cycles = `DISCH_CYC_3;
				3'h4:    cycles = `DISCH_CYC_4;
				3'h5:    cycles = `DISCH_CYC_5;
				3'h6:    cycles = `DISCH_CYC_6;
				default: cycles = `DISCH_CYC_7;
			endcase
		end
	endfunction

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q    <= 8'h00;
			active_q <= 1'b0;
		end else if (start) begin
			cnt_q    <= cycles(sel) - 8'h01;
			active_q <= 1'b1;
		end else if (cnt_q != 8'h00) begin
			cnt_q    <= cnt_q - 8'h01;
		end else begin
			active_q <= 1'b0;
		end
	end

endmodule // discharge_timer

`default_nettype wire

// File: src/cap_sense_timing_and_mux.v
// Operation
// - Rate field sets conversion length and result width: 12,13,14,16.
// - Discharge field selects primary reset time 0.75 to 12 microseconds.
// - Current field scales charge current: full, 1/8, 1/4, 3/8, 1/2, 7/8.
// - Disconnect bit isolates converter from all pins regardless of channel.
// - Channel field chooses pin; firmware or scan logic may load it.
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_regs.vh"

module cap_sense_timing_and_mux (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire [7:0]  sfr_addr,
	input  wire [7:0]  sfr_wdata,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	output reg  [7:0]  sfr_rdata_q,
	input  wire        scan_load,
	input  wire [5:0]  scan_channel,
	input  wire        discharge_start,
	output reg  [4:0]  conv_clocks_q,
	output reg  [4:0]  result_bits_q,
	output reg  [2:0]  discharge_time_select_q,
	output wire        discharge_active_q,
	output reg  [3:0]  charge_current_eighths_q,
	output reg         pin_disconnect_q,
	output reg  [5:0]  sense_channel_select_q,
	output reg  [63:0] pin_route_q
);

	// ************************************************
	// Register state
	// ************************************************
	reg  [7:0]  chan_sel_q;
	reg  [7:0]  timing_cfg_q;
	wire [63:0] route_d;
	wire [1:0]  rate;
	wire [2:0]  disch;
	wire [2:0]  curr;
	wire        disc;
	wire [5:0]  chan;
	wire        wr_timing;
	wire        wr_chan;
	genvar      g;

	// ************************************************
	// Field views
	// ************************************************
	assign rate  = timing_cfg_q[`RATE_MSB:`RATE_LSB];
	assign disch = timing_cfg_q[`DISCH_MSB:`DISCH_LSB];
	assign curr  = timing_cfg_q[`CURR_MSB:`CURR_LSB];
	assign disc  = chan_sel_q[`DISC_BIT];
	assign chan  = chan_sel_q[`CHAN_MSB:`CHAN_LSB];

	// ************************************************
	// Decoding functions
	// ************************************************
	// length per rate code
	function [4:0] conv_len;
		input [1:0] r;
		begin
			case (r)
				2'h0:    conv_len = `CONV_LEN_0;
				2'h1:    conv_len = `CONV_LEN_1;
				2'h2:    conv_len = `CONV_LEN_2;
				default: conv_len = `CONV_LEN_3;
			endcase
		end
	endfunction

	// Register select, shared by write and read paths
	function addr_hit;
		input [7:0] a;
		input [7:0] reg_addr;
		begin
			addr_hit = (a == reg_addr);
		end
	endfunction

	function [3:0] curr_eighths;
		input [2:0] c;
		begin
			case (c)
				3'h0:    curr_eighths = `CURR_FULL_EIGHTHS;
				3'h1:    curr_eighths = 4'h1;
				3'h2:    curr_eighths = 4'h2;
				3'h5:    curr_eighths = 4'h3;
				3'h4:    curr_eighths = 4'h4;
				3'h7:    curr_eighths = 4'h7;
				// Undefined codes fall back to full current
				default: curr_eighths = `CURR_FULL_EIGHTHS;
			endcase
		end
	endfunction

	// ************************************************
	// Timing configuration writes
	// ************************************************
	assign wr_timing = sfr_wr && addr_hit(sfr_addr, `TIMING_CFG_ADDR);
	assign wr_chan   = sfr_wr && addr_hit(sfr_addr, `CHAN_SEL_ADDR);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timing_cfg_q <= `TIMING_CFG_RESET;
		end else if (wr_timing) begin
			timing_cfg_q <= sfr_wdata;
		end
	end

	// ************************************************
	// Channel select writes
	// ************************************************
	// firmware or scan load
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_sel_q <= `CHAN_SEL_RESET;
		end else if (wr_chan) begin
			// Firmware write wins over a scan load
			chan_sel_q <= sfr_wdata;
		end else if (scan_load) begin
			// Scan leaves disconnect and reserved bits alone
			chan_sel_q[`CHAN_MSB:`CHAN_LSB] <= scan_channel;
		end
	end

	// ************************************************
	// Register bus reads
	// ************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			if (addr_hit(sfr_addr, `CHAN_SEL_ADDR)) begin
				sfr_rdata_q <= chan_sel_q;
			end else if (addr_hit(sfr_addr, `TIMING_CFG_ADDR)) begin
				sfr_rdata_q <= timing_cfg_q;
			end else begin
				// Unmapped addresses read as zero
				sfr_rdata_q <= 8'h00;
			end
		end
	end

	// ************************************************
	// Conversion rate outputs
	// ************************************************
	// length and width
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_clocks_q <= `CONV_LEN_1;
			result_bits_q <= `CONV_LEN_1;
		end else begin
			conv_clocks_q <= conv_len(rate);
			result_bits_q <= conv_len(rate);
		end
	end

	// ************************************************
	// Discharge and current outputs
	// ************************************************
	// discharge field copy
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			discharge_time_select_q <= 3'h0;
		end else begin
			discharge_time_select_q <= disch;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_current_eighths_q <= `CURR_FULL_EIGHTHS;
		end else begin
			charge_current_eighths_q <= curr_eighths(curr);
		end
	end

	// ************************************************
	// Pin routing
	// ************************************************
	// disconnect and channel copies
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_disconnect_q       <= 1'b0;
			sense_channel_select_q <= 6'h00;
		end else begin
			pin_disconnect_q       <= disc;
			sense_channel_select_q <= chan;
		end
	end

	// Reset route follows channel 0, connected
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_route_q <= 64'h0000000000000001;
		end else begin
			pin_route_q <= route_d;
		end
	end

	generate
		for (g = 0; g < 64; g = g + 1) begin : g_route
			assign route_d[g] = !disc && ({26'h0000000, chan} == g);
		end
	endgenerate

	// ************************************************
	// Discharge timing
	// ************************************************
	// discharge pulse
	discharge_timer u_discharge_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.start    (discharge_start),
		.sel      (disch),
		.active_q (discharge_active_q)
	);

endmodule // cap_sense_timing_and_mux

`default_nettype wire

// File: verif/cap_sense_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cap_sense_sva (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [7:0]  sfr_addr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_wr,
	input wire logic        scan_load,
	input wire logic [5:0]  scan_channel,
	input wire logic        discharge_start,
	input wire logic [4:0]  conv_clocks_q,
	input wire logic [4:0]  result_bits_q,
	input wire logic        discharge_active_q,
	input wire logic [2:0]  discharge_time_select_q,
	input wire logic [3:0]  charge_current_eighths_q,
	input wire logic        pin_disconnect_q,
	input wire logic [5:0]  sense_channel_select_q,
	input wire logic [63:0] pin_route_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic       tw = sfr_wr && sfr_addr == 8'hBE;
	wire logic       cw = sfr_wr && sfr_addr == 8'h9C;
	wire logic [1:0] rt = sfr_wdata[7:6];
	wire logic [2:0] ia = sfr_wdata[2:0];
	wire logic [2:0] dt = sfr_wdata[5:3];
	function automatic logic [3:0] cur(input logic [2:0] c);
		return c == 3'h1 ? 4'h1 : c == 3'h2 ? 4'h2 : c == 3'h5 ? 4'h3 : c == 3'h4 ? 4'h4 : c == 3'h7 ? 4'h7 : 4'h8;
	endfunction
	AST_RATE: assert property (tw |-> ##2 conv_clocks_q == ($past(rt, 2) == 2'h3 ? 5'h10 : 5'hC + $past(rt, 2))
		&& result_bits_q == conv_clocks_q) else $error("rate");
	AST_DISCH: assert property (discharge_start |-> ##[1:2] discharge_active_q) else $error("discharge");
	AST_CURR: assert property (tw |-> ##2 charge_current_eighths_q == cur($past(ia, 2))) else $error("current");
	AST_DSEL: assert property (tw |-> ##2 discharge_time_select_q == $past(dt, 2)) else $error("dsel");
	AST_ROUTE: assert property (pin_route_q == (pin_disconnect_q ? 64'h0 : 64'h1 << sense_channel_select_q))
		else $error("route");
	AST_SCAN: assert property (scan_load && !cw |-> ##2 sense_channel_select_q == $past(scan_channel, 2))
		else $error("scan");
endmodule // cap_sense_sva
bind cap_sense_timing_and_mux cap_sense_sva i_cap_sense_sva (.core_clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
	.scan_load, .scan_channel, .discharge_start, .conv_clocks_q, .result_bits_q, .discharge_active_q,
	.discharge_time_select_q,
	.charge_current_eighths_q, .pin_disconnect_q, .sense_channel_select_q, .pin_route_q);
`default_nettype wire

// File: verif/electrode_model.sv
`timescale 1ns/1ps
`default_nettype none
module electrode_model (
	input  wire logic [63:0] pin_route_q,
	output var  logic        touch_seen
);
	// Electrode on pin 5 is touched
	assign touch_seen = pin_route_q[5];
endmodule // electrode_model
`default_nettype wire

// File: verif/cap_sense_timing_and_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cap_sense_timing_and_mux_tb;
	logic        core_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, scan_load = 0, discharge_start = 0, rd_d = 0;
	logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata_q, q[$];
	logic [5:0]  scan_channel = 0, ch, sense_channel_select_q;
	logic [4:0]  conv_clocks_q, result_bits_q, e;
	logic [2:0]  discharge_time_select_q;
	logic [3:0]  charge_current_eighths_q;
	logic        discharge_active_q, pin_disconnect_q, touch_seen;
	logic [63:0] pin_route_q;
	logic [31:0] lf = 32'hA5B6;
	int          n_mismatch = 0, n_compared = 0, n;
	int          dlen[8] = '{15, 20, 24, 30, 40, 60, 120, 240};
	int          ia[8] = '{8, 1, 2, 8, 4, 3, 8, 7};
	always #25 core_clk = ~core_clk;
	cap_sense_timing_and_mux i_cap_sense_timing_and_mux (.core_clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
		.sfr_rdata_q, .scan_load, .scan_channel, .discharge_start, .conv_clocks_q, .result_bits_q,
		.discharge_time_select_q, .discharge_active_q, .charge_current_eighths_q, .pin_disconnect_q,
		.sense_channel_select_q, .pin_route_q);
	electrode_model i_electrode_model (.pin_route_q, .touch_seen);
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input logic [63:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= w;
		sfr_rd <= !w;
		if (!w)
			q.push_back(d);
		@(posedge core_clk);
		sfr_wr <= 0;
		sfr_rd <= 0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task results;
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		rd_d <= sfr_rd;
		if (rd_d)
			chk(sfr_rdata_q, q.pop_front());
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1;
		acc(0, 8'h9C, 8'h00);
		acc(0, 8'hBE, 8'h40);
		acc(0, 8'h11, 8'h00);
		for (int i = 0; i < 8; i++) begin
			acc(1, 8'hBE, {i[1:0], i[2:0], i[2:0]});
			acc(0, 8'hBE, {i[1:0], i[2:0], i[2:0]});
			e = i[1:0] == 3 ? 5'h10 : 5'hC + i[1:0];
			chk({conv_clocks_q, result_bits_q}, {e, e});
			chk(charge_current_eighths_q, ia[i]);
			chk(discharge_time_select_q, i[2:0]);
			@(posedge core_clk);
			discharge_start <= 1;
			@(posedge core_clk);
			discharge_start <= 0;
			n = 0;
			repeat (260) @(posedge core_clk) n += discharge_active_q;
			chk(n, dlen[i]);
		end
		for (int i = 0; i < 6; i++) begin
			lf = nx(lf);
			ch = i == 2 ? 6'h05 : lf % 38;
			acc(1, 8'h9C, {i[0], 1'b0, ch});
			chk(pin_route_q, i[0] ? 64'h0 : 64'h1 << ch);
			chk(touch_seen, !i[0] && ch == 5);
			@(posedge core_clk);
			scan_load <= 1;
			scan_channel <= ~ch;
			@(posedge core_clk);
			scan_load <= 0;
			repeat (2) @(posedge core_clk);
			#1;
			chk({pin_disconnect_q, sense_channel_select_q}, {i[0], ~ch});
		end
		acc(1, 8'hBE, 8'h40);
		results;
	end
endmodule // cap_sense_timing_and_mux_tb
`default_nettype wire
